// >>> logic/adsq_defines.svh
// Offsets, field positions, reset values and sizes of the result sequencer
`ifndef ADSQ_DEFINES_SVH
`define ADSQ_DEFINES_SVH
`define ADSQ_NCH        6
`define ADSQ_CW         24
`define ADSQ_AW         5
`define ADSQ_EV_W       3
// Map indices; the bus byte address is four times the index
`define ADSQ_A_RES0     5'h00
`define ADSQ_A_RES5     5'h05
`define ADSQ_A_SNAP     5'h08
`define ADSQ_A_GRP1END  5'h0b
`define ADSQ_A_STCOM    5'h0c
`define ADSQ_A_GRP2END  5'h0e
`define ADSQ_A_CAL0     5'h0f
`define ADSQ_A_CALN     5'h1a
`define ADSQ_A_SEC      5'h1f
`define ADSQ_I_CTRL     6'h20
`define ADSQ_I_IRQST    6'h21
`define ADSQ_I_IRQMSK   6'h22
`define ADSQ_I_SEQST    6'h23
// Control register fields
`define ADSQ_F_RDINC    0
`define ADSQ_F_WRINC    2
`define ADSQ_F_MERGE    3
`define ADSQ_F_OFFEN    4
`define ADSQ_F_GAINEN   5
`define ADSQ_F_WIDTH    6
// Event bits
`define ADSQ_EV_READY   0
`define ADSQ_EV_OVLAP   1
`define ADSQ_EV_SNAP    2
// Reset values and unity gain
`define ADSQ_CTRL_RST   8'h46
`define ADSQ_SNAP_RST   24'h333333
`define ADSQ_GAIN_ONE   25'sh0800000
`endif

// >>> logic/adsq_pkg.sv
// Types of the result sequencer
package adsq_pkg;
`include "adsq_defines.svh"
    typedef enum logic [1:0] {
        FR_IDLE  = 2'b00,
        FR_READ  = 2'b01,
        FR_WRITE = 2'b10
    } adsq_frame_type;

    typedef struct packed {
        logic [`ADSQ_NCH-1:0][`ADSQ_CW-1:0] live;
        logic [`ADSQ_NCH-1:0][`ADSQ_CW-1:0] lat;
        logic [`ADSQ_NCH-1:0][`ADSQ_CW-1:0] stage;
        logic [`ADSQ_NCH-1:0]               pend;
        logic [`ADSQ_CW-1:0]                snap;
        logic [7:0]                         ctrl;
        logic [`ADSQ_EV_W-1:0]              irq_st;
        logic [`ADSQ_EV_W-1:0]              irq_msk;
        logic                               irq;
        logic                               wait_r;
        logic [31:0]                        rdata;
        logic                               ready_n;
        adsq_frame_type                     fr;
        logic [`ADSQ_AW-1:0]                addr;
        logic                               load_pend;
        logic [31:0]                        shreg;
        logic [5:0]                         bitcnt;
        logic                               map_wr_stb;
        logic [`ADSQ_AW-1:0]                map_wr_addr;
        logic [`ADSQ_CW-1:0]                map_wr_data;
        logic [2:0]                         mclk_s;
        logic [`ADSQ_CW-1:0]                comp_s1;
        logic [`ADSQ_CW-1:0]                comp_s2;
    } adsq_state_type;
endpackage : adsq_pkg

// >>> logic/adsq_sequencer.sv
// Result registers, address sequencer and comparator snapshot
`timescale 1ns/1ps
`include "adsq_defines.svh"
module adsq_sequencer #(
    parameter int NCH = `ADSQ_NCH,
    parameter int CW  = `ADSQ_CW
) (
    input  wire logic                 core_clk_in,
    input  wire logic                 rst_b_in,
    input  wire logic [7:0]           avs_address_in,
    input  wire logic                 avs_read_in,
    input  wire logic                 avs_write_in,
    input  wire logic [31:0]          avs_writedata_in,
    input  wire logic [3:0]           avs_byteenable_in,
    output logic                      avs_waitrequest_out,
    output logic [31:0]               avs_readdata_out,
    output logic                      irq_out,
    input  wire logic [NCH-1:0]       conv_done_in,
    input  wire logic [NCH*CW-1:0]    conversion_code_in,
    input  wire logic [NCH*CW-1:0]    offset_corr_in,
    input  wire logic [NCH*CW-1:0]    gain_corr_in,
    output logic                      ready_out_n,
    input  wire logic                 modulator_sample_clock_in,
    input  wire logic [CW-1:0]        comparator_bits_in,
    input  wire logic                 frame_start_in,
    input  wire logic                 frame_read_in,
    input  wire logic [4:0]           frame_addr_in,
    input  wire logic                 frame_end_in,
    input  wire logic                 bit_stb_in,
    input  wire logic                 wr_word_stb_in,
    input  wire logic [CW-1:0]        wr_word_in,
    input  wire logic [CW-1:0]        map_rd_data_in,
    output logic                      sdo_out,
    output logic [4:0]                cur_addr_out,
    output logic                      map_wr_stb_out,
    output logic [4:0]                map_wr_addr_out,
    output logic [CW-1:0]             map_wr_data_out
);
    import adsq_pkg::*;

    ////////////////////////////////////////////////////////////////////
    adsq_state_type           st;
    adsq_state_type           n;
    logic [NCH-1:0][CW-1:0]   corr;
    logic [31:0]              rd_mux;
    logic [31:0]              wmask;
    logic [NCH-1:0]           all_pend;
    logic                     mclk_rise;
    logic                     any_upd;
    logic [`ADSQ_EV_W-1:0]    ev;
    logic [`ADSQ_EV_W-1:0]    ev_clr;
    logic [5:0]               idx;
    logic [31:0]              word;
    logic [5:0]               wbits;

    ////////////////////////////////////////////////////////////////////
    // Next address of the loop for a given increment mode
    function automatic logic [4:0] next_addr(input logic [4:0] a,
                                             input logic       wr,
                                             input logic [1:0] m);
        logic [4:0] r;
        r = a + 5'h01;
        if (wr)
        begin
            if (a == `ADSQ_A_SEC || a < `ADSQ_A_SNAP)
                r = `ADSQ_A_SNAP;
            else if (a >= `ADSQ_A_CALN)
                r = `ADSQ_A_SEC;
        end
        else if (m != 2'b00 && (a == 5'h06 || a == 5'h07))
            r = `ADSQ_A_SNAP;
        else if (m != 2'b00 && a > `ADSQ_A_CALN && a < `ADSQ_A_SEC)
            r = `ADSQ_A_SEC;
        else
        begin
            case (m)
                2'b11:
                begin
                    if (a == `ADSQ_A_RES5)
                        r = `ADSQ_A_SNAP;
                    else if (a == `ADSQ_A_CALN)
                        r = `ADSQ_A_SEC;
                    else if (a == `ADSQ_A_SEC)
                        r = `ADSQ_A_RES0;
                end
                2'b10:
                begin
                    if (a == `ADSQ_A_RES5)
                        r = `ADSQ_A_RES0;
                    else if (a == `ADSQ_A_CALN)
                        r = `ADSQ_A_SEC;
                    else if (a == `ADSQ_A_SEC)
                        r = `ADSQ_A_SNAP;
                end
                2'b01:
                begin
                    if (a <= `ADSQ_A_RES5)
                        r = a[0] ? a - 5'h01 : a + 5'h01;
                    else if (a == `ADSQ_A_GRP1END)
                        r = `ADSQ_A_SNAP;
                    else if (a == `ADSQ_A_GRP2END)
                        r = `ADSQ_A_STCOM;
                    else if (a >= `ADSQ_A_CAL0 && a <= `ADSQ_A_CALN)
                        r = a[0] ? a + 5'h01 : a - 5'h01;
                    else if (a == `ADSQ_A_SEC)
                        r = a;
                end
                default:
                    r = a;
            endcase
        end
        return r;
    endfunction : next_addr

    // Result word, left-aligned except the sign-extended 32-bit width, and its bit count
    function automatic logic [37:0] fmt(input logic [23:0] x,
                                        input logic [1:0]  w);
        logic [15:0] r16;
        r16 = x[23:8];
        case (w)
            2'b00:
            begin
                if (x[7] && r16 != 16'h7fff)
                    r16 = r16 + 16'h0001;
                fmt = {6'h10, r16, 16'h0000};
            end
            2'b01:   fmt = {6'h18, x, 8'h00};
            2'b10:   fmt = {6'h20, x, 8'h00};
            default: fmt = {6'h20, {8{x[23]}}, x};
        endcase
    endfunction : fmt

    ////////////////////////////////////////////////////////////////////
    // Per-channel correction
    for (genvar i = 0; i < NCH; i++)
    begin : g_corr
        logic signed [CW-1:0] raw;
        logic signed [CW-1:0] off;
        logic signed [CW:0]   gmul;
        logic signed [49:0]   prod;
        assign raw  = $signed(conversion_code_in[i*CW +: CW]);
        assign off  = st.ctrl[`ADSQ_F_OFFEN] ?
                      raw + $signed(offset_corr_in[i*CW +: CW]) : raw;
        assign gmul = `ADSQ_GAIN_ONE +
                      $signed({gain_corr_in[i*CW+CW-1], gain_corr_in[i*CW +: CW]});
        assign prod = off * gmul;
        assign corr[i] = st.ctrl[`ADSQ_F_GAINEN] ? prod[46:23] : off;
    end

    ////////////////////////////////////////////////////////////////////
    // Register read multiplexer
    always_comb
    begin
        idx    = avs_address_in[7:2];
        rd_mux = 32'h0000_0000;
        if (idx <= {1'b0, `ADSQ_A_RES5})
            rd_mux = {8'h00, st.live[idx[2:0]]};
        else if (idx == {1'b0, `ADSQ_A_SNAP})
            rd_mux = {8'h00, st.snap};
        else if (idx == `ADSQ_I_CTRL)
            rd_mux = {24'h000000, st.ctrl};
        else if (idx == `ADSQ_I_IRQST)
            rd_mux = {29'h0, st.irq_st};
        else if (idx == `ADSQ_I_IRQMSK)
            rd_mux = {29'h0, st.irq_msk};
        else if (idx == `ADSQ_I_SEQST)
            rd_mux = {18'h00000, st.pend, st.load_pend, st.fr, st.addr};
        for (int b = 0; b < 4; b++)
            wmask[b*8 +: 8] = {8{avs_byteenable_in[b]}};
    end

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        n          = st;
        ev         = '0;
        ev_clr     = '0;
        word       = 32'h0000_0000;
        wbits      = 6'h18;
        any_upd    = 1'b0;
        n.ready_n  = 1'b1;
        n.map_wr_stb = 1'b0;
        // Two-stage sync of modulator clock and bits
        n.mclk_s  = {st.mclk_s[1:0], modulator_sample_clock_in};
        n.comp_s1 = comparator_bits_in;
        n.comp_s2 = st.comp_s1;
        mclk_rise = st.mclk_s[1] & ~st.mclk_s[2];
        if (mclk_rise)
        begin
            n.snap = st.comp_s2;
            ev[`ADSQ_EV_SNAP] = 1'b1;
        end

        // Conversion capture
        all_pend = st.pend | conv_done_in;
        if (st.ctrl[`ADSQ_F_MERGE])
        begin
            for (int i = 0; i < NCH; i++)
                if (conv_done_in[i])
                    n.stage[i] = corr[i];
            n.pend = all_pend;
            if (&all_pend)
            begin
                for (int i = 0; i < NCH; i++)
                    n.live[i] = conv_done_in[i] ? corr[i] : st.stage[i];
                n.pend    = '0;
                n.ready_n = 1'b0;
                any_upd   = 1'b1;
            end
        end
        else
        begin
            n.pend = '0;
            for (int i = 0; i < NCH; i++)
                if (conv_done_in[i])
                    n.live[i] = corr[i];
            if (|conv_done_in)
            begin
                n.ready_n = 1'b0;
                any_upd   = 1'b1;
            end
        end
        ev[`ADSQ_EV_READY] = any_upd;
        // newest kept live, frozen copy served
        ev[`ADSQ_EV_OVLAP] = any_upd && st.fr == FR_READ;

        if (st.fr != FR_READ)
            n.lat = st.live;

        // Serial frames
        if (frame_start_in)
        begin
            n.addr      = frame_addr_in;
            n.fr        = frame_read_in ? FR_READ : FR_WRITE;
            n.load_pend = frame_read_in;
            n.lat       = st.live;
        end
        else if (frame_end_in)
        begin
            n.fr        = FR_IDLE;
            n.load_pend = 1'b0;
        end
        else if (st.fr == FR_READ && st.load_pend)
        begin
            if (st.addr <= `ADSQ_A_RES5)
                {wbits, word} = fmt(st.lat[st.addr[2:0]], st.ctrl[`ADSQ_F_WIDTH +: 2]);
            else if (st.addr == `ADSQ_A_SNAP)
                word = {st.snap, 8'h00};
            else
                word = {map_rd_data_in, 8'h00};
            n.shreg     = word;
            n.bitcnt    = wbits;
            n.load_pend = 1'b0;
        end
        else if (st.fr == FR_READ && bit_stb_in)
        begin
            n.shreg  = {st.shreg[30:0], 1'b0};
            n.bitcnt = st.bitcnt - 6'h01;
            if (st.bitcnt == 6'h01)
            begin
                n.addr      = next_addr(st.addr, 1'b0, st.ctrl[`ADSQ_F_RDINC +: 2]);
                n.load_pend = 1'b1;
            end
        end
        else if (st.fr == FR_WRITE && wr_word_stb_in)
        begin
            if (st.addr == `ADSQ_A_SNAP)
                n.snap = wr_word_in;
            else if (st.addr > `ADSQ_A_RES5)
            begin
                n.map_wr_stb  = 1'b1;
                n.map_wr_addr = st.addr;
                n.map_wr_data = wr_word_in;
            end
            if (st.ctrl[`ADSQ_F_WRINC])
                n.addr = next_addr(st.addr, 1'b1, 2'b00);
        end

        // Bus slave: one wait cycle, then answer
        if ((avs_read_in || avs_write_in) && st.wait_r)
        begin
            n.wait_r = 1'b0;
            // Read data hold until the next read answer
            if (avs_read_in)
                n.rdata = rd_mux;
        end
        else
            n.wait_r = 1'b1;
        if (avs_write_in && !st.wait_r)
        begin
            if (idx == {1'b0, `ADSQ_A_SNAP})
                n.snap = (st.snap & ~wmask[CW-1:0]) | (avs_writedata_in[CW-1:0] & wmask[CW-1:0]);
            else if (idx == `ADSQ_I_CTRL && avs_byteenable_in[0])
                n.ctrl = avs_writedata_in[7:0];
            else if (idx == `ADSQ_I_IRQST && avs_byteenable_in[0])
                ev_clr = avs_writedata_in[`ADSQ_EV_W-1:0];
            else if (idx == `ADSQ_I_IRQMSK && avs_byteenable_in[0])
                n.irq_msk = avs_writedata_in[`ADSQ_EV_W-1:0];
        end

        // Sticky events, set wins over clear
        n.irq_st = (st.irq_st & ~ev_clr) | ev;
        n.irq    = |(n.irq_st & n.irq_msk);
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            st         <= '0;
            st.snap    <= `ADSQ_SNAP_RST;
            st.ctrl    <= `ADSQ_CTRL_RST;
            st.wait_r  <= 1'b1;
            st.ready_n <= 1'b1;
            st.fr      <= FR_IDLE;
        end
        else
            st <= n;
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs straight from state
    assign avs_waitrequest_out = st.wait_r;
    assign avs_readdata_out    = st.rdata;
    assign irq_out             = st.irq;
    assign ready_out_n         = st.ready_n;
    assign sdo_out             = st.shreg[31];
    assign cur_addr_out        = st.addr;
    assign map_wr_stb_out      = st.map_wr_stb;
    assign map_wr_addr_out     = st.map_wr_addr;
    assign map_wr_data_out     = st.map_wr_data;
endmodule : adsq_sequencer

// >>> tb/adsq_checker.sv
// Port-level checks of the result sequencer
`timescale 1ns/1ps
module adsq_checker #(
    parameter int NCH = 6,
    parameter int CW  = 24
) (
    input wire logic           core_clk_in,
    input wire logic           rst_b_in,
    input wire logic           avs_read_in,
    input wire logic           avs_write_in,
    input wire logic           avs_waitrequest_out,
    input wire logic [31:0]    avs_readdata_out,
    input wire logic [NCH-1:0] conv_done_in,
    input wire logic           ready_out_n,
    input wire logic           frame_start_in,
    input wire logic           frame_read_in,
    input wire logic [4:0]     frame_addr_in,
    input wire logic           wr_word_stb_in,
    input wire logic [CW-1:0]  wr_word_in,
    input wire logic [4:0]     cur_addr_out,
    input wire logic           map_wr_stb_out,
    input wire logic [4:0]     map_wr_addr_out,
    input wire logic [CW-1:0]  map_wr_data_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    ////////////////////////////////////////////////////////////////////////
    // Steps of bus and serial write
    sequence s_req; $rose(avs_read_in || avs_write_in); endsequence
    sequence s_ack; !avs_waitrequest_out; endsequence
    sequence s_wr_high; wr_word_stb_in && cur_addr_out > 5'h08; endsequence
    ////////////////////////////////////////////////////////////////////////
    property p_ack_time; s_req |=> s_ack; endproperty
    a_ack_time: assert property (p_ack_time) else $error("late bus answer");
    property p_ack_one; s_ack |-> (avs_read_in || avs_write_in) ##1 avs_waitrequest_out; endproperty
    a_ack_one: assert property (p_ack_one) else $error("stray bus answer");
    property p_rdata_hold; !$stable(avs_readdata_out) |-> s_ack and avs_read_in; endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_ready_cause; !ready_out_n |-> $past(|conv_done_in); endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready without done");
    property p_start_addr;
        frame_start_in && frame_read_in && !(frame_addr_in inside {5'h06, 5'h07, [5'h1b:5'h1e]})
            |=> cur_addr_out == $past(frame_addr_in);
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("bad start address");
    property p_wr_fwd;
        s_wr_high |=> map_wr_stb_out && map_wr_addr_out == $past(cur_addr_out) && map_wr_data_out == $past(wr_word_in);
    endproperty
    a_wr_fwd: assert property (p_wr_fwd) else $error("write not forwarded");
    property p_wr_drop; wr_word_stb_in && cur_addr_out <= 5'h05 |=> !map_wr_stb_out; endproperty
    a_wr_drop: assert property (p_wr_drop) else $error("result write forwarded");
    property p_wr_skip; map_wr_stb_out |-> map_wr_addr_out > 5'h08 && !(map_wr_addr_out inside {[5'h1b:5'h1e]}); endproperty
    a_wr_skip: assert property (p_wr_skip) else $error("bad map write address");
endmodule : adsq_checker

bind adsq_sequencer adsq_checker #(.NCH(NCH), .CW(CW)) u_chk (.*);

// >>> tb/adsq_host_model.sv
// Host on the serial side: opens frames, strobes bits and words
`timescale 1ns/1ps
module adsq_host_model (
    input  wire logic        core_clk_in,
    input  wire logic        sdo_in,
    output logic             frame_start_out,
    output logic             frame_read_out,
    output logic [4:0]       frame_addr_out,
    output logic             frame_end_out,
    output logic             bit_stb_out,
    output logic             wr_word_stb_out,
    output logic [23:0]      wr_word_out
);
    logic [31:0] words_q[$];
    // Idle levels
    initial
    begin
        frame_start_out = 1'b0;
        frame_read_out = 1'b0;
        frame_addr_out = 5'h00;
        frame_end_out = 1'b0;
        bit_stb_out = 1'b0;
        wr_word_stb_out = 1'b0;
        wr_word_out = 24'h000000;
    end
    // Frame start, address dropped once taken
    task automatic open_frame(input logic r, input logic [4:0] a);
        @(posedge core_clk_in);
        frame_start_out <= 1'b1;
        frame_read_out <= r;
        frame_addr_out <= a;
        @(posedge core_clk_in);
        frame_start_out <= 1'b0;
        frame_addr_out <= ~a;
        @(posedge core_clk_in);
    endtask : open_frame
    task automatic close_frame;
        @(posedge core_clk_in);
        frame_end_out <= 1'b1;
        @(posedge core_clk_in);
        frame_end_out <= 1'b0;
    endtask : close_frame
    // Read words, MSB first, strobes three cycles apart
    task automatic rd_frame(input logic [4:0] a, input int nb, input int nw);
        logic [31:0] w;
        open_frame(1'b1, a);
        repeat (nw)
        begin
            w = 32'h0;
            repeat (nb)
            begin
                @(posedge core_clk_in);
                w = {w[30:0], sdo_in};
                bit_stb_out <= 1'b1;
                @(posedge core_clk_in);
                bit_stb_out <= 1'b0;
                @(posedge core_clk_in);
            end
            words_q.push_back(w);
            @(posedge core_clk_in);
        end
        close_frame();
    endtask : rd_frame
    // snapshot writes only in tests
    // Write words; junk between strobes
    task automatic wr_frame(input logic [4:0] a, input logic [71:0] ws, input int nw);
        open_frame(1'b0, a);
        for (int i = 0; i < nw; i++)
        begin
            @(posedge core_clk_in);
            wr_word_stb_out <= 1'b1;
            wr_word_out <= ws[24 * i +: 24];
            @(posedge core_clk_in);
            wr_word_stb_out <= 1'b0;
            wr_word_out <= ~ws[24 * i +: 24];
            @(posedge core_clk_in);
        end
        close_frame();
    endtask : wr_frame
endmodule : adsq_host_model

// >>> tb/adsq_sequencer_tb_top.sv
// Bench of the result sequencer: bus, frames, conversions, snapshot
`timescale 1ns/1ps
module adsq_sequencer_tb_top;
    logic         clk = 1'b0;
    logic         rst_b = 1'b0;
    logic [7:0]   adr = 8'h00;
    logic         rd = 1'b0;
    logic         wr = 1'b0;
    logic [31:0]  wd = 32'h0;
    logic [5:0]   done = 6'h00;
    logic [143:0] code = 144'h0;
    logic [143:0] offs = 144'h0;
    logic [143:0] gain = 144'h0;
    logic         mclk = 1'b0;
    logic         mrun = 1'b0;
    logic [23:0]  comp = 24'h000000;
    logic         wreq, irq, rdy_n, sdo, fs, frd, fe, bs, ws, mws;
    logic [4:0]   fa, cur, mwa;
    logic [23:0]  ww, mwd;
    logic [31:0]  rdat, v;
    logic [28:0]  mw_q[$];
    int           n_fail = 0;
    int           num_checks = 0;
    int           n_rdy = 0;
    int           k;
    ////////////////////////////////////////////////////////////////////////
    // Core clock; modulator clock stands still while mrun is low
    always #4 clk = ~clk;
    initial
    begin
        #3;
        forever #32 mclk = mrun ? ~mclk : mclk;
    end
    // Map writes and ready pulses seen
    always @(posedge clk)
    begin
        if (mws === 1'b1)
            mw_q.push_back({mwa, mwd});
        if (rdy_n === 1'b0)
            n_rdy++;
    end
    adsq_sequencer u_dut (
        .core_clk_in(clk), .rst_b_in(rst_b), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wd), .avs_byteenable_in(4'hf), .avs_waitrequest_out(wreq), .avs_readdata_out(rdat),
        .irq_out(irq), .conv_done_in(done), .conversion_code_in(code), .offset_corr_in(offs),
        .gain_corr_in(gain), .ready_out_n(rdy_n), .modulator_sample_clock_in(mclk), .comparator_bits_in(comp),
        .frame_start_in(fs), .frame_read_in(frd), .frame_addr_in(fa), .frame_end_in(fe), .bit_stb_in(bs),
        .wr_word_stb_in(ws), .wr_word_in(ww), .map_rd_data_in({8'ha5, 11'h000, cur}), .sdo_out(sdo),
        .cur_addr_out(cur), .map_wr_stb_out(mws), .map_wr_addr_out(mwa), .map_wr_data_out(mwd));
    adsq_host_model u_host (
        .core_clk_in(clk), .sdo_in(sdo), .frame_start_out(fs), .frame_read_out(frd), .frame_addr_out(fa),
        .frame_end_out(fe), .bit_stb_out(bs), .wr_word_stb_out(ws), .wr_word_out(ww));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] cd(input int i);
        return 24'h812345 + 24'(i) * 24'h020202;
    endfunction : cd
    function automatic logic [31:0] r16(input logic [23:0] r);
        return {16'h0, r[23:8] + {15'h0, r[7]}};
    endfunction : r16
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Bus read and compare
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, v, e);
    endtask : rdc
    // One bus access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= ~w;
        wd <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wreq !== 1'b0 && n < 100);
        v = rdat;
        if (n >= 100)
            n_fail++;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic conv(input int ch, input logic [23:0] c);
        @(posedge clk);
        code[24 * ch +: 24] <= c;
        done <= 6'h01 << ch;
        @(posedge clk);
        done <= 6'h00;
        repeat (3) @(posedge clk);
    endtask : conv
    task automatic srd(input logic [7:0] c, input logic [4:0] a, input int nb, input logic [95:0] e);
        bus(1'b1, 8'h80, {24'h0, c});
        u_host.rd_frame(a, nb, 3);
        for (int i = 0; i < 3; i++)
            chk("serial word", u_host.words_q.pop_front(), e[32 * i +: 32]);
        $display("test serial read done");
    endtask : srd
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial
    begin
        repeat (30000) @(posedge clk);
        n_fail++;
        summarize();
    end
    // Test sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rdc("ctrl reset", 8'h80, 32'h46);
        rdc("snapshot reset", 8'h20, 32'h333333);
        chk("ready idle", 32'(rdy_n), 32'h1);
        $display("test reset done");
        for (int i = 0; i < 6; i++)
        begin
            k = n_rdy;
            conv(i, cd(i));
            chk("ready pulses", 32'(n_rdy - k), 32'h1);
            rdc("result", 8'(4 * i), {8'h00, cd(i)});
        end
        bus(1'b1, 8'h0c, 32'h00ffffff);
        rdc("result write", 8'h0c, {8'h00, cd(3)});
        bus(1'b1, 8'h1c, 32'h5);
        rdc("unmapped", 8'h1c, 32'h0);
        $display("test results done");
        srd(8'h46, 5'h04, 24, {8'h00, cd(0), 8'h00, cd(5), 8'h00, cd(4)});
        srd(8'h45, 5'h01, 24, {8'h00, cd(1), 8'h00, cd(0), 8'h00, cd(1)});
        srd(8'h47, 5'h05, 24, {32'ha50009, 32'h333333, 8'h00, cd(5)});
        srd(8'h04, 5'h02, 16, {3{r16(cd(2))}});
        srd(8'hc6, 5'h00, 32, {8'hff, cd(2), 8'hff, cd(1), 8'hff, cd(0)});
        bus(1'b1, 8'h80, 32'h46);
        bus(1'b1, 8'h84, 32'h7);
        fork
            u_host.rd_frame(5'h00, 24, 2);
            begin
                repeat (30) @(posedge clk);
                conv(1, 24'h0abcde);
            end
        join
        chk("frozen word 0", u_host.words_q.pop_front(), {8'h00, cd(0)});
        chk("frozen word 1", u_host.words_q.pop_front(), {8'h00, cd(1)});
        rdc("late result", 8'h04, 32'h0abcde);
        bus(1'b0, 8'h84, 32'h0);
        chk("update in frame", v & 32'h2, 32'h2);
        $display("test freeze done");
        bus(1'b1, 8'h84, 32'h7);
        bus(1'b1, 8'h88, 32'h1);
        conv(2, 24'h123456);
        chk("irq raised", 32'(irq), 32'h1);
        bus(1'b1, 8'h84, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'(irq), 32'h0);
        bus(1'b1, 8'h88, 32'h0);
        conv(2, 24'h123457);
        chk("irq masked", 32'(irq), 32'h0);
        rdc("status sticky", 8'h84, 32'h1);
        $display("test interrupt done");
        bus(1'b1, 8'h80, 32'h4e);
        k = n_rdy;
        for (int i = 0; i < 5; i++)
            conv(i, ~cd(i));
        rdc("merge hold", 8'h00, {8'h00, cd(0)});
        conv(5, ~cd(5));
        chk("merge pulses", 32'(n_rdy - k), 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            rdc("merged result", 8'(4 * i), {8'h00, ~cd(i)});
        end
        $display("test merge done");
        comp <= 24'h5a1c3e;
        mrun <= 1'b1;
        repeat (40) @(posedge clk);
        mrun <= 1'b0;
        rdc("snapshot", 8'h20, 32'h5a1c3e);
        bus(1'b0, 8'h84, 32'h0);
        chk("snapshot event", v & 32'h4, 32'h4);
        $display("test snapshot done");
        bus(1'b1, 8'h80, 32'h46);
        mw_q.delete();
        u_host.wr_frame(5'h1a, {24'h0c0c0c, 24'h0b0b0b, 24'h0a0a0a}, 3);
        chk("map writes", 32'(mw_q.size()), 32'h2);
        chk("map write 0", 32'(mw_q[0]), {3'h0, 5'h1a, 24'h0a0a0a});
        chk("map write 1", 32'(mw_q[1]), {3'h0, 5'h1f, 24'h0b0b0b});
        rdc("snapshot wrap", 8'h20, 32'h0c0c0c);
        mw_q.delete();
        bus(1'b1, 8'h80, 32'h42);
        u_host.wr_frame(5'h03, {3{24'h777777}}, 2);
        chk("static writes", 32'(mw_q.size()), 32'h0);
        rdc("result kept", 8'h0c, {8'h00, ~cd(3)});
        $display("test serial write done");
        bus(1'b1, 8'h80, 32'h76);
        offs[23:0] <= 24'h000010;
        gain[23:0] <= 24'h400000;
        conv(0, 24'h100000);
        rdc("corrected", 8'h00, 32'h180018);
        $display("test correction done");
        summarize();
    end
endmodule : adsq_sequencer_tb_top
